// >>> srg_params.svh
// Purpose: Constants shared by the status register groups.
// Assumes: Included by its bare name from the package, srg_group and srg_top.
// Notes:   Select codes pick one register of one group per request.
`ifndef SRG_PARAMS_SVH
`define SRG_PARAMS_SVH

`define SRG_W            16
`define SRG_SEL_W        4
`define SRG_STB_W        8
`define SRG_SUM_OPER_BIT 7
`define SRG_SUM_QUES_BIT 3
`define SRG_ZERO         16'h0000
`define SRG_ONES         16'hffff
`define SRG_COND_RST     16'h0000
`define SRG_EVENT_RST    16'h0000
`define SRG_ENABLE_RST   16'h0000
`define SRG_NTR_RST      16'h0000
`define SRG_PTR_RST      16'hffff
`define SRG_STB_RST      8'h00

`define SRG_SEL_OPERATION_CONDITION 4'h0
`define SRG_SEL_OPERATION_ENABLE 4'h1
`define SRG_SEL_OPER_EVT  4'h2
`define SRG_SEL_OPER_NEG  4'h3
`define SRG_SEL_OPER_POS  4'h4
`define SRG_SEL_QUESTIONABLE_CONDITION 4'h5
`define SRG_SEL_QUESTIONABLE_ENABLE 4'h6
`define SRG_SEL_QUES_EVT  4'h7
`define SRG_SEL_QUES_NEG  4'h8
`define SRG_SEL_QUES_POS  4'h9

`endif

// >>> srg_pkg.sv
// Purpose: Types shared by the status register groups.
// Assumes: The constants header is available by its bare name.
// Notes:   Registers of one group travel together as one struct.
`default_nettype none
package srg_pkg;
`include "srg_params.svh"

	typedef enum logic [`SRG_SEL_W-1:0] {
		SRG_SEL_OPERATION_CONDITION = `SRG_SEL_OPERATION_CONDITION,
		SRG_SEL_OPERATION_ENABLE = `SRG_SEL_OPERATION_ENABLE,
		SRG_SEL_OPER_EVT  = `SRG_SEL_OPER_EVT,
		SRG_SEL_OPER_NEG  = `SRG_SEL_OPER_NEG,
		SRG_SEL_OPER_POS  = `SRG_SEL_OPER_POS,
		SRG_SEL_QUESTIONABLE_CONDITION = `SRG_SEL_QUESTIONABLE_CONDITION,
		SRG_SEL_QUESTIONABLE_ENABLE = `SRG_SEL_QUESTIONABLE_ENABLE,
		SRG_SEL_QUES_EVT  = `SRG_SEL_QUES_EVT,
		SRG_SEL_QUES_NEG  = `SRG_SEL_QUES_NEG,
		SRG_SEL_QUES_POS  = `SRG_SEL_QUES_POS
	} srg_sel_e;

	typedef struct packed {
		logic              valid;
		logic              write;
		srg_sel_e          sel;
		logic [`SRG_W-1:0] data;
	} srg_req_s;

	typedef struct packed {
		logic              valid;
		logic [`SRG_W-1:0] data;
	} srg_rsp_s;

	typedef struct packed {
		logic wr_enable;
		logic wr_neg;
		logic wr_pos;
		logic rd_event;
	} srg_ctl_s;

	typedef struct packed {
		logic [`SRG_W-1:0] condition;
		logic [`SRG_W-1:0] enable;
		logic [`SRG_W-1:0] events;
		logic [`SRG_W-1:0] neg_filter;
		logic [`SRG_W-1:0] pos_filter;
	} srg_regs_s;
endpackage
`default_nettype wire

// >>> srg_decode.sv
// Purpose: Turns a host request into per-group write and read strobes.
// Assumes: The request is valid for one cycle per command.
// Notes:   Writes to condition and event registers are ignored.
`timescale 1ns/1ps
`default_nettype none
module srg_decode
	import srg_pkg::*;
(
	input  wire srg_req_s req_in,
	output var  srg_ctl_s oper_ctl_out,
	output var  srg_ctl_s ques_ctl_out
);
	logic wr;
	logic rd;

	assign wr = req_in.valid && req_in.write;
	assign rd = req_in.valid && !req_in.write;

	always_comb begin
		oper_ctl_out.wr_enable = wr && (req_in.sel == SRG_SEL_OPERATION_ENABLE);
		oper_ctl_out.wr_neg    = wr && (req_in.sel == SRG_SEL_OPER_NEG);
		oper_ctl_out.wr_pos    = wr && (req_in.sel == SRG_SEL_OPER_POS);
		oper_ctl_out.rd_event  = rd && (req_in.sel == SRG_SEL_OPER_EVT);
		ques_ctl_out.wr_enable = wr && (req_in.sel == SRG_SEL_QUESTIONABLE_ENABLE);
		ques_ctl_out.wr_neg    = wr && (req_in.sel == SRG_SEL_QUES_NEG);
		ques_ctl_out.wr_pos    = wr && (req_in.sel == SRG_SEL_QUES_POS);
		ques_ctl_out.rd_event  = rd && (req_in.sel == SRG_SEL_QUES_EVT);
	end
endmodule
`default_nettype wire

// >>> srg_group.sv
// Purpose: One status group: condition, filters, sticky events, enable.
// Assumes: Monitor inputs are synchronous to the clock.
// Notes:   Bits outside USED_MASK read as zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "srg_params.svh"
module srg_group
	import srg_pkg::*;
#(
	parameter logic [`SRG_W-1:0] USED_MASK = `SRG_ONES
) (
	input  wire logic              clk_in,
	input  wire logic              reset_in,
	input  wire logic [`SRG_W-1:0] monitor_in,
	input  wire srg_ctl_s          ctl_in,
	input  wire logic [`SRG_W-1:0] wdata_in,
	input  wire logic              clear_in,
	input  wire logic              preset_in,
	output var  srg_regs_s         regs_out
);
	if (USED_MASK == `SRG_ZERO) begin : g_bad_mask
		$error("A status group needs at least one used bit.");
	end

	srg_regs_s         regs;
	srg_regs_s         next_regs;
	logic [`SRG_W-1:0] rise;
	logic [`SRG_W-1:0] fall;

	always_comb begin
		next_regs = regs;
		next_regs.condition = monitor_in & USED_MASK;
		rise = next_regs.condition & ~regs.condition;
		fall = regs.condition & ~next_regs.condition;
		if (preset_in) begin
			next_regs.enable     = `SRG_ENABLE_RST;
			next_regs.neg_filter = `SRG_NTR_RST;
			next_regs.pos_filter = `SRG_PTR_RST & USED_MASK;
		end else begin
			if (ctl_in.wr_enable) begin
				next_regs.enable = wdata_in & USED_MASK;
			end
			if (ctl_in.wr_neg) begin
				next_regs.neg_filter = wdata_in & USED_MASK;
			end
			if (ctl_in.wr_pos) begin
				next_regs.pos_filter = wdata_in & USED_MASK;
			end
		end
		// A new event in the clearing cycle survives the clear.
		if (clear_in || ctl_in.rd_event) begin
			next_regs.events = `SRG_EVENT_RST;
		end
		next_regs.events = next_regs.events
			| (rise & regs.pos_filter)
			| (fall & regs.neg_filter);
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			regs.condition  <= `SRG_COND_RST;
			regs.enable     <= `SRG_ENABLE_RST;
			regs.events     <= `SRG_EVENT_RST;
			regs.neg_filter <= `SRG_NTR_RST;
			regs.pos_filter <= `SRG_PTR_RST & USED_MASK;
		end else begin
			regs <= next_regs;
		end
	end

	assign regs_out = regs;
endmodule
`default_nettype wire

// >>> srg_top.sv
// Purpose: Operation and questionable status groups with a host port.
// Assumes: One clock; reset_in is the power-on reset.
// Notes:   Read answers and status byte bits lag by one clock.
`timescale 1ns/1ps
`default_nettype none
`include "srg_params.svh"
module srg_top
	import srg_pkg::*;
#(
	parameter logic [`SRG_W-1:0] OPER_USED_MASK = `SRG_ONES,
	parameter logic [`SRG_W-1:0] QUES_USED_MASK = `SRG_ONES
) (
	input  wire logic                  clk_in,
	input  wire logic                  reset_in,
	input  wire logic [`SRG_W-1:0]     oper_monitor_in,
	input  wire logic [`SRG_W-1:0]     ques_monitor_in,
	input  wire srg_req_s              req_in,
	input  wire logic                  clear_status_in,
	input  wire logic                  preset_in,
	output var  srg_rsp_s              rsp_out,
	output var  logic [`SRG_STB_W-1:0] status_byte_out
);
	////////////////////////////////////////////////////////////////////
	// Request decode and the two groups.

	srg_ctl_s              oper_ctl;
	srg_ctl_s              ques_ctl;
	srg_regs_s             oper_regs;
	srg_regs_s             ques_regs;
	srg_rsp_s              rsp;
	srg_rsp_s              next_rsp;
	logic [`SRG_STB_W-1:0] status_byte;
	logic [`SRG_STB_W-1:0] next_status_byte;

	srg_decode u_decode (
		.req_in       (req_in),
		.oper_ctl_out (oper_ctl),
		.ques_ctl_out (ques_ctl)
	);

	// Writes to the condition and event registers are dropped.
	srg_group #(
		.USED_MASK (OPER_USED_MASK)
	) u_oper (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.monitor_in (oper_monitor_in),
		.ctl_in     (oper_ctl),
		.wdata_in   (req_in.data),
		.clear_in   (clear_status_in),
		.preset_in  (preset_in),
		.regs_out   (oper_regs)
	);

	srg_group #(
		.USED_MASK (QUES_USED_MASK)
	) u_ques (
		.clk_in     (clk_in),
		.reset_in   (reset_in),
		.monitor_in (ques_monitor_in),
		.ctl_in     (ques_ctl),
		.wdata_in   (req_in.data),
		.clear_in   (clear_status_in),
		.preset_in  (preset_in),
		.regs_out   (ques_regs)
	);

	////////////////////////////////////////////////////////////////////
	// Read answer and status byte summary.

	function automatic logic summary_of(input srg_regs_s r);
		return |(r.events & r.enable);
	endfunction

	always_comb begin
		next_rsp.valid = req_in.valid && !req_in.write;
		next_rsp.data  = `SRG_ZERO;
		if (next_rsp.valid) begin
			case (req_in.sel)
				SRG_SEL_OPERATION_CONDITION: next_rsp.data = oper_regs.condition;
				SRG_SEL_OPERATION_ENABLE: next_rsp.data = oper_regs.enable;
				SRG_SEL_OPER_EVT:  next_rsp.data = oper_regs.events;
				SRG_SEL_OPER_NEG:  next_rsp.data = oper_regs.neg_filter;
				SRG_SEL_OPER_POS:  next_rsp.data = oper_regs.pos_filter;
				SRG_SEL_QUESTIONABLE_CONDITION: next_rsp.data = ques_regs.condition;
				SRG_SEL_QUESTIONABLE_ENABLE: next_rsp.data = ques_regs.enable;
				SRG_SEL_QUES_EVT:  next_rsp.data = ques_regs.events;
				SRG_SEL_QUES_NEG:  next_rsp.data = ques_regs.neg_filter;
				SRG_SEL_QUES_POS:  next_rsp.data = ques_regs.pos_filter;
				default:           next_rsp.data = `SRG_ZERO;
			endcase
		end
		next_status_byte = `SRG_STB_RST;
		next_status_byte[`SRG_SUM_OPER_BIT] = summary_of(oper_regs);
		next_status_byte[`SRG_SUM_QUES_BIT] = summary_of(ques_regs);
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rsp         <= '0;
			status_byte <= `SRG_STB_RST;
		end else begin
			rsp         <= next_rsp;
			status_byte <= next_status_byte;
		end
	end

	assign rsp_out         = rsp;
	assign status_byte_out = status_byte;

	////////////////////////////////////////////////////////////////////
	// Checks.

	logic [`SRG_W-1:0] oper_mon;
	logic [`SRG_W-1:0] oper_pos_hit;
	logic [`SRG_W-1:0] oper_neg_hit;
	logic [`SRG_W-1:0] ques_mon;
	logic [`SRG_W-1:0] ques_pos_hit;
	logic [`SRG_W-1:0] ques_neg_hit;
	logic              oper_any_hit;
	logic              ques_any_hit;
	logic              oper_sum_now;
	logic              ques_sum_now;

	assign oper_mon     = oper_monitor_in & OPER_USED_MASK;
	assign ques_mon     = ques_monitor_in & QUES_USED_MASK;
	assign oper_pos_hit = oper_mon & ~oper_regs.condition
		& oper_regs.pos_filter;
	assign oper_neg_hit = ~oper_mon & oper_regs.condition
		& oper_regs.neg_filter;
	assign ques_pos_hit = ques_mon & ~ques_regs.condition
		& ques_regs.pos_filter;
	assign ques_neg_hit = ~ques_mon & ques_regs.condition
		& ques_regs.neg_filter;
	assign oper_any_hit = |(oper_pos_hit | oper_neg_hit);
	assign ques_any_hit = |(ques_pos_hit | ques_neg_hit);
	assign oper_sum_now = |(oper_regs.events & oper_regs.enable);
	assign ques_sum_now = |(ques_regs.events & ques_regs.enable);

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	property p_operation_condition_rst;
		disable iff (1'b0)
		reset_in |=> (oper_regs.condition == `SRG_COND_RST);
	endproperty
	a_operation_condition_rst: assert property (p_operation_condition_rst)
		else $error("Operation condition not zero after reset.");

	property p_questionable_condition_rst;
		disable iff (1'b0)
		reset_in |=> (ques_regs.condition == `SRG_COND_RST);
	endproperty
	a_questionable_condition_rst: assert property (p_questionable_condition_rst)
		else $error("Questionable condition not zero after reset.");

	property p_cond_follow;
		1'b1 |=> (oper_regs.condition ==
			($past(oper_monitor_in) & OPER_USED_MASK));
	endproperty
	a_cond_follow: assert property (p_cond_follow)
		else $error("Condition does not follow its monitor.");

	property p_cond_read;
		(req_in.valid && !req_in.write
			&& req_in.sel == SRG_SEL_QUESTIONABLE_CONDITION)
		|=> rsp_out.valid
			&& (rsp_out.data == $past(ques_regs.condition))
			&& (ques_regs.condition == $past(ques_mon));
	endproperty
	a_cond_read: assert property (p_cond_read)
		else $error("Condition read wrong or disturbed.");

	property p_unused_zero;
		((rsp_out.data & ~OPER_USED_MASK & ~QUES_USED_MASK)
			== `SRG_ZERO)
		&& ((oper_regs.enable | oper_regs.events | oper_regs.condition
			| oper_regs.pos_filter | oper_regs.neg_filter)
			& ~OPER_USED_MASK) == `SRG_ZERO;
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("Unused bit reads as one.");

	property p_write_enable;
		(oper_ctl.wr_enable && !preset_in)
		|=> (oper_regs.enable ==
			($past(req_in.data) & OPER_USED_MASK));
	endproperty
	a_write_enable: assert property (p_write_enable)
		else $error("Enable write not stored.");

	property p_write_neg;
		(ques_ctl.wr_neg && !preset_in)
		|=> (ques_regs.neg_filter ==
			($past(req_in.data) & QUES_USED_MASK));
	endproperty
	a_write_neg: assert property (p_write_neg)
		else $error("Negative filter write not stored.");

	property p_pos_edge;
		(oper_pos_hit != `SRG_ZERO)
		|=> ((oper_regs.events & $past(oper_pos_hit))
			== $past(oper_pos_hit));
	endproperty
	a_pos_edge: assert property (p_pos_edge)
		else $error("Rising edge missed its event.");

	property p_neg_edge;
		(ques_neg_hit != `SRG_ZERO)
		|=> ((ques_regs.events & $past(ques_neg_hit))
			== $past(ques_neg_hit));
	endproperty
	a_neg_edge: assert property (p_neg_edge)
		else $error("Falling edge missed its event.");

	property p_no_spurious;
		(!oper_any_hit)
		|=> ((oper_regs.events & ~$past(oper_regs.events))
			== `SRG_ZERO);
	endproperty
	a_no_spurious: assert property (p_no_spurious)
		else $error("Event set without a selected edge.");

	property p_sticky;
		(!oper_ctl.rd_event && !clear_status_in)
		|=> ((oper_regs.events & $past(oper_regs.events))
			== $past(oper_regs.events));
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("Event bit lost without a read.");

	property p_oper_read_clear;
		(oper_ctl.rd_event && !oper_any_hit)
		|=> (rsp_out.data == $past(oper_regs.events))
			&& (oper_regs.events == `SRG_ZERO);
	endproperty
	a_oper_read_clear: assert property (p_oper_read_clear)
		else $error("Operation event read did not clear.");

	property p_ques_cls;
		(clear_status_in && !ques_any_hit)
		|=> (ques_regs.events == `SRG_ZERO);
	endproperty
	a_ques_cls: assert property (p_ques_cls)
		else $error("Clear-status left questionable events.");

	property p_ques_evt_rst;
		disable iff (1'b0)
		reset_in |=> (ques_regs.events == `SRG_EVENT_RST)
			&& (oper_regs.events == `SRG_EVENT_RST);
	endproperty
	a_ques_evt_rst: assert property (p_ques_evt_rst)
		else $error("Events not zero after reset.");

	property p_oper_sum;
		1'b1 |=> (status_byte_out[`SRG_SUM_OPER_BIT] == $past(oper_sum_now));
	endproperty
	a_oper_sum: assert property (p_oper_sum)
		else $error("Status byte bit 7 wrong.");

	property p_ques_sum;
		1'b1 |=> (status_byte_out[`SRG_SUM_QUES_BIT] == $past(ques_sum_now));
	endproperty
	a_ques_sum: assert property (p_ques_sum)
		else $error("Status byte bit 3 wrong.");

	property p_preset;
		preset_in
		|=> (oper_regs.enable == `SRG_ENABLE_RST)
			&& (ques_regs.enable == `SRG_ENABLE_RST)
			&& (oper_regs.neg_filter == `SRG_NTR_RST)
			&& (ques_regs.neg_filter == `SRG_NTR_RST);
	endproperty
	a_preset: assert property (p_preset)
		else $error("Preset did not clear enables and negative filters.");

	property p_preset_pos;
		preset_in
		|=> (oper_regs.pos_filter == (`SRG_PTR_RST & OPER_USED_MASK))
			&& (ques_regs.pos_filter == (`SRG_PTR_RST & QUES_USED_MASK));
	endproperty
	a_preset_pos: assert property (p_preset_pos)
		else $error("Preset did not set positive filters.");

	property p_filter_rst;
		disable iff (1'b0)
		reset_in |=> (oper_regs.neg_filter == `SRG_NTR_RST)
			&& (ques_regs.enable == `SRG_ENABLE_RST)
			&& (ques_regs.pos_filter == (`SRG_PTR_RST & QUES_USED_MASK));
	endproperty
	a_filter_rst: assert property (p_filter_rst)
		else $error("Filters or enables wrong after reset.");

	property p_preset_keep;
		(preset_in && !oper_any_hit && !oper_ctl.rd_event
			&& !clear_status_in)
		|=> $stable(oper_regs.events)
			&& (oper_regs.condition == $past(oper_mon));
	endproperty
	a_preset_keep: assert property (p_preset_keep)
		else $error("Preset disturbed events or condition.");

	property p_settings_hold;
		(!preset_in && !ques_ctl.wr_enable && !ques_ctl.wr_pos)
		|=> $stable(ques_regs.enable) && $stable(ques_regs.pos_filter);
	endproperty
	a_settings_hold: assert property (p_settings_hold)
		else $error("Questionable settings changed without a write.");

	property p_ques_read_clear;
		(ques_ctl.rd_event && !ques_any_hit)
		|=> (rsp_out.data == $past(ques_regs.events))
			&& (ques_regs.events == `SRG_ZERO);
	endproperty
	a_ques_read_clear: assert property (p_ques_read_clear)
		else $error("Questionable event read did not clear.");

	property p_oper_cls;
		(clear_status_in && !oper_any_hit)
		|=> (oper_regs.events == `SRG_ZERO);
	endproperty
	a_oper_cls: assert property (p_oper_cls)
		else $error("Clear-status left operation events.");
endmodule
`default_nettype wire

// >>> srg_host.sv
// Purpose: Host command side issuing status reads, writes and commands.
// Assumes: Requests change 1 ns after a rising edge and last one cycle.
// Notes:   A read answer is taken one cycle after its request edge.
`timescale 1ns/1ps
`default_nettype none
module srg_host
	import srg_pkg::*;
(
	input  wire logic     clk_in,
	input  wire srg_rsp_s rsp_in,
	output var  srg_req_s req_out,
	output var  logic     clear_out,
	output var  logic     preset_out
);
	initial begin
		req_out = '0;
		clear_out = 1'b0;
		preset_out = 1'b0;
	end

	// One request; the answer registered at the taking edge is read back.
	task automatic access(input logic wr, input logic [3:0] sel,
		input logic [15:0] d, output logic v, output logic [15:0] q);
		@(posedge clk_in);
		#1;
		req_out = {1'b1, wr, sel, d};
		@(posedge clk_in);
		#1;
		req_out = '0;
		v = rsp_in.valid;
		q = rsp_in.data;
	endtask

	task automatic cmd(input logic clr, input logic pre);
		@(posedge clk_in);
		#1;
		clear_out = clr;
		preset_out = pre;
		@(posedge clk_in);
		#1;
		clear_out = 1'b0;
		preset_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for both status register groups.
// Assumes: Operation group has bit 15 unused; questionable uses all 16.
// Notes:   Group 2 with offsets 0..5 walks the unmapped selects 10..15.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("Error %0d ns: got %h want %h", $time, g, e); end end
module testbench import srg_pkg::*;;
	localparam logic [15:0] MASK [2] = '{16'h7fff, 16'hffff};
	logic       clk_in = 1'b0;
	logic       reset_in = 1'b1;
	logic [15:0] mon [2] = '{16'h0, 16'h0};
	srg_req_s   req;
	srg_rsp_s   rsp;
	logic       clr;
	logic       pre;
	logic [7:0] sb;
	int         n_fail = 0;
	int         n_tests = 0;

	always #20 clk_in = ~clk_in;

	srg_top #(.OPER_USED_MASK(16'h7fff), .QUES_USED_MASK(16'hffff))
	srg_top_inst (.clk_in(clk_in), .reset_in(reset_in),
		.oper_monitor_in(mon[0]), .ques_monitor_in(mon[1]),
		.req_in(req), .clear_status_in(clr), .preset_in(pre),
		.rsp_out(rsp), .status_byte_out(sb));

	srg_host srg_host_inst (.clk_in(clk_in), .rsp_in(rsp), .req_out(req),
		.clear_out(clr), .preset_out(pre));

	////////////////////////////////////////////////////////////////////
	task automatic chk_reg(input int g, input int k, input logic [15:0] e);
		logic v;
		logic [15:0] q;
		srg_host_inst.access(1'b0, 4'(g * 5 + k), 16'h0, v, q);
		`CHK(v, 1'b1)
		`CHK(q, e)
	endtask

	task automatic wr(input int g, input int k, input logic [15:0] d);
		logic v;
		logic [15:0] q;
		srg_host_inst.access(1'b1, 4'(g * 5 + k), d, v, q);
	endtask

	// Changes a monitor, then lets condition, event and summary settle.
	task automatic set_mon(input int g, input logic [15:0] d);
		@(posedge clk_in);
		#1;
		mon[g] = d;
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	function automatic logic sum_bit(input int g);
		return g ? sb[3] : sb[7];
	endfunction

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int g = 0; g < 2; g++) begin
			for (int k = 0; k < 5; k++) begin
				chk_reg(g, k, k == 4 ? MASK[g] : 16'h0);
			end
			set_mon(g, 16'h0001);
			chk_reg(g, 2, 16'h0001);
			set_mon(g, 16'h0000);
			chk_reg(g, 2, 16'h0000);
		end
		for (int k = 0; k < 6; k++) begin
			chk_reg(2, k, 16'h0);
		end
		`CHK(sb, 8'h00)
	endtask

	task automatic t_write_preset();
		for (int g = 0; g < 2; g++) begin
			for (int k = 1; k < 5; k++) begin
				wr(g, k, 16'hffff);
			end
			chk_reg(g, 1, MASK[g]);
			chk_reg(g, 3, MASK[g]);
			wr(g, 0, 16'hffff);
			chk_reg(g, 0, 16'h0);
			set_mon(g, 16'h0001);
			`CHK(sum_bit(g), 1'b1)
			srg_host_inst.cmd(1'b0, 1'b1);
			chk_reg(g, 0, 16'h0001);
			chk_reg(g, 2, 16'h0001);
			for (int k = 1; k < 5; k++) begin
				chk_reg(g, k, k == 4 ? MASK[g] : 16'h0);
			end
			`CHK(sum_bit(g), 1'b0)
			set_mon(g, 16'h0000);
		end
	endtask

	task automatic t_edges();
		for (int g = 0; g < 2; g++) begin
			wr(g, 4, 16'h0001);
			wr(g, 3, 16'h0002);
			wr(g, 1, 16'h0002);
			set_mon(g, 16'h0003);
			`CHK(sum_bit(g), 1'b0)
			set_mon(g, 16'h0000);
			`CHK(sum_bit(g), 1'b1)
			set_mon(g, 16'h8004);
			chk_reg(g, 0, 16'h8004 & MASK[g]);
			chk_reg(g, 0, 16'h8004 & MASK[g]);
			chk_reg(g, 2, 16'h0003);
			chk_reg(g, 2, 16'h0000);
			`CHK(sum_bit(g), 1'b0)
			set_mon(g, 16'h0000);
		end
	endtask

	task automatic t_clear();
		for (int g = 0; g < 2; g++) begin
			wr(g, 1, 16'h0001);
			set_mon(g, 16'h0001);
			`CHK(sum_bit(g), 1'b1)
			`CHK(sb & 8'h77, 8'h00)
			srg_host_inst.cmd(1'b1, 1'b0);
			@(posedge clk_in);
			#1;
			`CHK(sum_bit(g), 1'b0)
			chk_reg(g, 2, 16'h0000);
			chk_reg(g, 0, 16'h0001);
			set_mon(g, 16'h0000);
		end
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("Tests %0d, failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		t_reset();
		t_write_preset();
		t_edges();
		t_clear();
		test_done();
	end

	// The run needs well under 1000 cycles; 5000 means a hang.
	initial begin
		#200000;
		n_fail++;
		test_done();
	end
endmodule
`default_nettype wire
